// *** src/ltsi_pkg.sv ***
// constants shared by the light sensor threshold interrupt block
package ltsi_pkg;
    // register offsets on the device's internal byte port
    localparam logic [7:0] REG_INT_CTL = 8'h02;
    localparam logic [7:0] REG_LOW_LSB = 8'h03;
    localparam logic [7:0] REG_LOW_MSB = 8'h04;
    localparam logic [7:0] REG_HIGH_LSB = 8'h05;
    localparam logic [7:0] REG_HIGH_MSB = 8'h06;
    // interrupt control field layout
    localparam int HALT_BIT = 6;
    localparam int MODE_MSB = 5;
    localparam int MODE_LSB = 4;
    localparam int PERS_MSB = 3;
    localparam int PERS_LSB = 0;
    localparam int CTL_MSB = 6;
    // reset values, counter limit and step, and the every-conversion persistence code
    localparam logic [6:0] INT_CTL_RESET = 7'h00;
    localparam logic [15:0] THR_RESET = 16'h0000;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [3:0] PERSIST_EVERY = 4'h0;
    localparam logic [7:0] RDATA_NONE = 8'h00;
    // interrupt modes
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_LEVEL = 2'h1,
        MODE_ALERT = 2'h2,
        MODE_TEST = 2'h3
    } ltsi_mode_type;
    // alert response cycle
    localparam logic [6:0] ARA_ADDR = 7'h0C;
    localparam logic ARA_READ = 1'b1;
    localparam logic RESP_LSB = 1'b0;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BITS_RESET = 4'h0;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
endpackage : ltsi_pkg

// *** src/ltsi_alert_resp.sv ***
// alert response address responder with arbitration on the returned address byte
`timescale 1ns/1ps
module ltsi_alert_resp #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic alert_active,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic ara_won,
    output logic ara_lost
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_AACK = 5'h04,
        ST_DATA = 5'h08,
        ST_WAIT = 5'h10
    } ltsi_ara_state_type;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        ltsi_ara_state_type state;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic drive;
        logic won;
        logic lost;
    } ltsi_ara_type;

    ltsi_ara_type q, d;
    logic rise, fall, start, stop;

    ////////////////////////////////////////////////////////////////////////////////
    // edges seen on the second sync stage only; the first stage feeds nothing else
    assign rise = q.scl_s2 & ~q.scl_p;
    assign fall = ~q.scl_s2 & q.scl_p;
    assign start = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
    assign stop = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;

    // next state; data changes only while the clock is low
    always_comb begin
        d = q;
        d.scl_s1 = scl_in;
        d.scl_s2 = q.scl_s1;
        d.scl_p = q.scl_s2;
        d.sda_s1 = sda_in;
        d.sda_s2 = q.sda_s1;
        d.sda_p = q.sda_s2;
        d.won = 1'b0;
        d.lost = 1'b0;
        if (start) begin
            d.state = ST_ADDR;
            d.bits = ltsi_pkg::BITS_RESET;
            d.drive = 1'b0;
        end else if (stop) begin
            d.state = ST_IDLE;
            d.drive = 1'b0;
        end else begin
            unique case (q.state)
                ST_IDLE: begin
                    d.drive = 1'b0;
                end
                ST_ADDR: begin
                    if (rise) begin
                        d.shreg = {q.shreg[6:0], q.sda_s2};
                        d.bits = q.bits + ltsi_pkg::BIT_STEP;
                    end else if (fall && q.bits == ltsi_pkg::BYTE_BITS) begin
                        // only answer the alert address while our own alert stands
                        if (q.shreg == {ltsi_pkg::ARA_ADDR, ltsi_pkg::ARA_READ}
                                && alert_active) begin
                            d.drive = 1'b1;
                            d.state = ST_AACK;
                        end else begin
                            d.state = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (fall) begin
                        // own address in the upper seven bits of the byte
                        d.shreg = {DEV_ADDR, ltsi_pkg::RESP_LSB};
                        d.bits = ltsi_pkg::BITS_RESET;
                        d.drive = ~DEV_ADDR[6];
                        d.state = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rise) begin
                        if (!q.drive && !q.sda_s2) begin
                            // a lower address pulled low: back off, alert stays
                            d.lost = 1'b1;
                            d.drive = 1'b0;
                            d.state = ST_IDLE;
                        end else begin
                            d.shreg = {q.shreg[6:0], 1'b0};
                            d.bits = q.bits + ltsi_pkg::BIT_STEP;
                            d.won = (q.bits == ltsi_pkg::LAST_BIT);
                        end
                    end else if (fall) begin
                        if (q.bits == ltsi_pkg::BYTE_BITS) begin
                            d.drive = 1'b0;
                            d.state = ST_WAIT;
                        end else begin
                            d.drive = ~q.shreg[7];
                        end
                    end
                end
                ST_WAIT: begin
                    d.drive = 1'b0;
                end
                default: begin
                    d.state = ST_IDLE;
                    d.drive = 1'b0;
                end
            endcase
        end
    end

    // state register; sync flops reset high to match an idle bus
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                   sda_p: 1'b1, state: ST_IDLE, bits: ltsi_pkg::BITS_RESET,
                   shreg: ltsi_pkg::SHIFT_RESET, drive: 1'b0, won: 1'b0, lost: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = ~q.drive;
    assign ara_won = q.won;
    assign ara_lost = q.lost;
endmodule : ltsi_alert_resp

// *** src/ltsi_core.sv ***
// threshold comparison, persistence filter and interrupt output of the light sensor
`timescale 1ns/1ps
module ltsi_core #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic cmd_clear,
    input wire logic conv_done,
    input wire logic [15:0] ch0_data,
    output logic integ_halt,
    output logic int_out,
    output logic int_oe_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n
);
    typedef struct packed {
        logic [6:0] ctl;
        logic [15:0] low_thr;
        logic [15:0] high_thr;
        logic [3:0] cnt;
        logic irq;
        logic halt;
        logic [7:0] rdata;
    } ltsi_core_state_type;

    ltsi_core_state_type q, d;
    ltsi_pkg::ltsi_mode_type mode;
    logic [3:0] persist;
    logic out_of_range, in_range_hit, trigger, test_set, set_irq, clr_irq;
    logic [3:0] cnt_next;
    logic ara_won, ara_lost, alert_active;

    ////////////////////////////////////////////////////////////////////////////////
    // field decode of the control register
    assign mode = ltsi_pkg::ltsi_mode_type'(q.ctl[ltsi_pkg::MODE_MSB:ltsi_pkg::MODE_LSB]);
    assign persist = q.ctl[ltsi_pkg::PERS_MSB:ltsi_pkg::PERS_LSB];

    // window test on channel 0 only; no channel 1 input exists here
    assign out_of_range = (ch0_data <= q.low_thr)
                        | (ch0_data > q.high_thr);
    assign in_range_hit = conv_done & ~out_of_range;

    // saturating run length so a long excursion does not wrap back below the limit
    assign cnt_next = (q.cnt == ltsi_pkg::CNT_MAX) ? q.cnt : q.cnt + ltsi_pkg::CNT_STEP;

    // persistence filter decides whether this conversion raises the interrupt
    always_comb begin
        trigger = 1'b0;
        if (conv_done && mode != ltsi_pkg::MODE_OFF) begin
            if (persist == ltsi_pkg::PERSIST_EVERY) begin
                trigger = 1'b1;
            end else begin
                trigger = out_of_range && (cnt_next >= persist);
            end
        end
    end

    // writing the test code raises the interrupt right after the write
    assign test_set = reg_wr_en && reg_addr == ltsi_pkg::REG_INT_CTL
                    && reg_wdata[ltsi_pkg::MODE_MSB:ltsi_pkg::MODE_LSB] == ltsi_pkg::MODE_TEST;
    assign set_irq = trigger | test_set;

    // command clear works in every mode, which is also the resume path after a halt
    // alert response clears only when won; a lost arbitration clears nothing
    always_comb begin
        clr_irq = cmd_clear;
        if ((mode == ltsi_pkg::MODE_ALERT || mode == ltsi_pkg::MODE_TEST) && ara_won) begin
            clr_irq = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state of registers, counter and pending flag
    always_comb begin
        d = q;
        if (reg_wr_en) begin
            unique case (reg_addr)
                ltsi_pkg::REG_INT_CTL: d.ctl = reg_wdata[ltsi_pkg::CTL_MSB:0];
                ltsi_pkg::REG_LOW_LSB: d.low_thr[7:0] = reg_wdata;
                ltsi_pkg::REG_LOW_MSB: d.low_thr[15:8] = reg_wdata;
                ltsi_pkg::REG_HIGH_LSB: d.high_thr[7:0] = reg_wdata;
                ltsi_pkg::REG_HIGH_MSB: d.high_thr[15:8] = reg_wdata;
                default: d.ctl = q.ctl;
            endcase
        end
        // run length of out-of-range results, reset by any in-range result
        if (in_range_hit) begin
            d.cnt = ltsi_pkg::CNT_RESET;
        end else if (conv_done) begin
            d.cnt = cnt_next;
        end
        // set wins over a clear landing in the same cycle
        if (set_irq) begin
            d.irq = 1'b1;
        end else if (clr_irq) begin
            d.irq = 1'b0;
        end
        // halt follows the pending flag while enabled
        d.halt = d.irq && d.ctl[ltsi_pkg::HALT_BIT]
               && d.ctl[ltsi_pkg::MODE_MSB:ltsi_pkg::MODE_LSB] != ltsi_pkg::MODE_OFF;
        // read data; reserved top bit of control reads zero
        unique case (reg_addr)
            ltsi_pkg::REG_INT_CTL: d.rdata = {1'b0, d.ctl};
            ltsi_pkg::REG_LOW_LSB: d.rdata = d.low_thr[7:0];
            ltsi_pkg::REG_LOW_MSB: d.rdata = d.low_thr[15:8];
            ltsi_pkg::REG_HIGH_LSB: d.rdata = d.high_thr[7:0];
            ltsi_pkg::REG_HIGH_MSB: d.rdata = d.high_thr[15:8];
            default: d.rdata = ltsi_pkg::RDATA_NONE;
        endcase
    end

    // state register; thresholds come up at zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '{ctl: ltsi_pkg::INT_CTL_RESET, low_thr: ltsi_pkg::THR_RESET,
                   high_thr: ltsi_pkg::THR_RESET, cnt: ltsi_pkg::CNT_RESET, irq: 1'b0,
                   halt: 1'b0, rdata: ltsi_pkg::RDATA_NONE};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // open-drain pin: value fixed low, enable pulls it; off mode never drives
    assign alert_active = q.irq && mode != ltsi_pkg::MODE_OFF;
    assign int_out = 1'b0;
    assign int_oe_n = ~alert_active;
    assign integ_halt = q.halt;
    assign reg_rdata = q.rdata;

    // alert response cycle on the serial pins
    ltsi_alert_resp #(
        .DEV_ADDR(DEV_ADDR)
    ) u_alert_resp (
        .ref_clk(ref_clk),
        .reset(reset),
        .alert_active(alert_active),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .ara_won(ara_won),
        .ara_lost(ara_lost)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks on the interrupt path
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    property p_level_single;
        conv_done && mode == ltsi_pkg::MODE_LEVEL && persist == 4'h1 && out_of_range
            |=> q.irq ##0 !int_oe_n;
    endproperty
    a_level_single: assert property (p_level_single) else $error("level irq missed");

    property p_hold;
        q.irq && !cmd_clear && !ara_won |=> q.irq;
    endproperty
    a_hold: assert property (p_hold) else $error("irq dropped without clear");

    property p_level_clear;
        q.irq && mode == ltsi_pkg::MODE_LEVEL && cmd_clear && !set_irq |=> !q.irq ##0 int_oe_n;
    endproperty
    a_level_clear: assert property (p_level_clear) else $error("clear code ignored");

    property p_ara_clear;
        ara_won && mode == ltsi_pkg::MODE_ALERT && !set_irq |=> !q.irq;
    endproperty
    a_ara_clear: assert property (p_ara_clear) else $error("won alert not cleared");

    property p_ara_lost;
        ara_lost && q.irq && !cmd_clear |=> q.irq;
    endproperty
    a_ara_lost: assert property (p_ara_lost) else $error("lost arbitration cleared");

    property p_test_set;
        test_set |=> q.irq ##0 !int_oe_n;
    endproperty
    a_test_set: assert property (p_test_set) else $error("test mode irq missing");

    property p_off;
        mode == ltsi_pkg::MODE_OFF |-> int_oe_n;
    endproperty
    a_off: assert property (p_off) else $error("irq driven while disabled");

    property p_halt;
        trigger && q.ctl[ltsi_pkg::HALT_BIT] && !reg_wr_en |=> integ_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("integration not halted");

    property p_every;
        conv_done && persist == ltsi_pkg::PERSIST_EVERY && mode != ltsi_pkg::MODE_OFF
            |=> q.irq;
    endproperty
    a_every: assert property (p_every) else $error("every-cycle irq missed");

    property p_persist_run;
        conv_done && out_of_range && persist > 4'h1 && cnt_next < persist && !q.irq
            && !test_set |=> !q.irq;
    endproperty
    a_persist_run: assert property (p_persist_run) else $error("irq before persistence");

    property p_low_edge;
        conv_done && ch0_data == q.low_thr && persist == 4'h1 && mode == ltsi_pkg::MODE_LEVEL
            |=> q.irq;
    endproperty
    a_low_edge: assert property (p_low_edge) else $error("equal low not out of range");

    property p_high_edge;
        conv_done && ch0_data == q.high_thr && ch0_data > q.low_thr && !q.irq && !test_set
            && persist != ltsi_pkg::PERSIST_EVERY |=> !q.irq;
    endproperty
    a_high_edge: assert property (p_high_edge) else $error("equal high raised irq");

    property p_restart;
        in_range_hit |=> q.cnt == ltsi_pkg::CNT_RESET;
    endproperty
    a_restart: assert property (p_restart) else $error("run counter not restarted");

    property p_thr_write;
        reg_wr_en && reg_addr == ltsi_pkg::REG_LOW_MSB |=> q.low_thr[15:8] == $past(reg_wdata);
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold byte lost");

    // remaining bytes land where addressed
    property p_low_lsb;
        reg_wr_en && reg_addr == ltsi_pkg::REG_LOW_LSB |=> q.low_thr[7:0] == $past(reg_wdata);
    endproperty
    a_low_lsb: assert property (p_low_lsb) else $error("low lsb lost");

    property p_high_lsb;
        reg_wr_en && reg_addr == ltsi_pkg::REG_HIGH_LSB
            |=> q.high_thr[7:0] == $past(reg_wdata);
    endproperty
    a_high_lsb: assert property (p_high_lsb) else $error("high lsb lost");

    property p_high_msb;
        reg_wr_en && reg_addr == ltsi_pkg::REG_HIGH_MSB
            |=> q.high_thr[15:8] == $past(reg_wdata);
    endproperty
    a_high_msb: assert property (p_high_msb) else $error("high msb lost");

    property p_ctl_write;
        reg_wr_en && reg_addr == ltsi_pkg::REG_INT_CTL
            |=> q.ctl == $past(reg_wdata[ltsi_pkg::CTL_MSB:0]);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control lost");

    // read data trails the pointer by one cycle
    property p_rd_low;
        reg_addr == ltsi_pkg::REG_LOW_LSB && !reg_wr_en
            |=> reg_rdata == $past(q.low_thr[7:0]);
    endproperty
    a_rd_low: assert property (p_rd_low) else $error("low lsb misread");

    property p_rd_high;
        reg_addr == ltsi_pkg::REG_HIGH_MSB && !reg_wr_en
            |=> reg_rdata == $past(q.high_thr[15:8]);
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("high msb misread");

    // unless persistence is zero, only an out run or a test write may raise the flag
    property p_in_range;
        conv_done && !out_of_range && persist != ltsi_pkg::PERSIST_EVERY && !q.irq
            && !test_set |=> !q.irq;
    endproperty
    a_in_range: assert property (p_in_range) else $error("in-range irq");

    property p_off_quiet;
        mode == ltsi_pkg::MODE_OFF && !q.irq && !test_set |=> !q.irq;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("irq set while off");

    property p_level_ara;
        mode == ltsi_pkg::MODE_LEVEL && q.irq && !cmd_clear |=> q.irq;
    endproperty
    a_level_ara: assert property (p_level_ara) else $error("level irq lost");

    property p_test_ara;
        ara_won && mode == ltsi_pkg::MODE_TEST && !set_irq |=> !q.irq;
    endproperty
    a_test_ara: assert property (p_test_ara) else $error("test irq kept");

    // run counter steps on outs and saturates rather than wrap
    property p_count;
        conv_done && out_of_range && q.cnt != ltsi_pkg::CNT_MAX
            |=> q.cnt == $past(q.cnt) + ltsi_pkg::CNT_STEP;
    endproperty
    a_count: assert property (p_count) else $error("run count slipped");

    property p_sat;
        conv_done && out_of_range && q.cnt == ltsi_pkg::CNT_MAX |=> q.cnt == ltsi_pkg::CNT_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("run count wrapped");

    // halt drops with the flag and never stands while off
    property p_halt_clr;
        cmd_clear && !set_irq |=> !integ_halt;
    endproperty
    a_halt_clr: assert property (p_halt_clr) else $error("halt kept after clear");

    property p_halt_off;
        mode == ltsi_pkg::MODE_OFF |-> !integ_halt;
    endproperty
    a_halt_off: assert property (p_halt_off) else $error("halt while off");

    // the loser lets go of data in the same cycle
    property p_lost_release;
        ara_lost |-> sda_oe_n;
    endproperty
    a_lost_release: assert property (p_lost_release) else $error("sda held after loss");

    c_level: cover property (mode == ltsi_pkg::MODE_LEVEL && trigger ##[1:1000] cmd_clear);
    c_test: cover property (test_set);
    c_ara_won: cover property (ara_won);
    c_ara_lost: cover property (ara_lost);
    c_halt: cover property (integ_halt);
endmodule : ltsi_core

// *** dv/ltsi_host_model.sv ***
// host bus controller model that runs alert response cycles on the pins
`timescale 1ns/1ps
module ltsi_host_model #(
    parameter logic [6:0] RIVAL_ADDR = 7'h10
) (
    output logic scl,
    output logic host_pull,
    output logic rival_pull,
    input wire logic sda
);
    ////////////////////////////////////////////////////////////////////////////////
    // idle bus: clock stands high outside frames, nothing pulled
    initial begin
        scl = 1'b1;
        host_pull = 1'b0;
        rival_pull = 1'b0;
    end

    // receive byte at the alert response address, 48 ns bus clock
    // rival is a second alerting device with a lower address, for arbitration loss
    task automatic ara(input logic rival, output logic [7:0] got, output logic acked);
        logic [7:0] abyte;
        logic [7:0] rbyte;
        abyte = {ltsi_pkg::ARA_ADDR, ltsi_pkg::ARA_READ};
        rbyte = {RIVAL_ADDR, 1'b0};
        host_pull = 1'b1;
        #24 scl = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #12 host_pull = ~abyte[i];
            #12 scl = 1'b1;
            #24 scl = 1'b0;
        end
        #12 host_pull = 1'b0;
        rival_pull = rival;
        #12 scl = 1'b1;
        #12 acked = ~sda;
        #12 scl = 1'b0;
        // data bits sampled mid-high; device drives while clock is low
        for (int i = 7; i >= 0; i--) begin
            #12 rival_pull = rival & ~rbyte[i];
            #12 scl = 1'b1;
            #12 got[i] = sda;
            #12 scl = 1'b0;
        end
        #12 rival_pull = 1'b0;
        #12 scl = 1'b1;
        #24 scl = 1'b0;
        // stop: data rises while clock is high
        #12 host_pull = 1'b1;
        #12 scl = 1'b1;
        #12 host_pull = 1'b0;
        #24;
    endtask : ara
endmodule : ltsi_host_model

// *** dv/ltsi_core_bench.sv ***
// self-checking bench for the threshold interrupt core
`timescale 1ns/1ps
module ltsi_core_bench;
    localparam logic [6:0] DEV_ADDR = 7'h2A; // arbitrary bus address
    logic ref_clk;
    logic reset;
    logic reg_wr_en;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic cmd_clear;
    logic conv_done;
    logic [15:0] ch0_data;
    logic integ_halt;
    logic int_out;
    logic int_oe_n;
    logic sda_out;
    logic sda_oe_n;
    logic scl;
    logic host_pull;
    logic rival_pull;
    logic sda;
    logic int_pin;
    logic [7:0] got;
    logic acked;
    int n_errors;
    int checks_done;

    ////////////////////////////////////////////////////////////////////////////////
    // pull-ups on both open-drain wires
    assign sda = (host_pull | rival_pull) ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);
    assign int_pin = int_oe_n ? 1'b1 : int_out;

    ltsi_core #(.DEV_ADDR(DEV_ADDR)) uut (
        .ref_clk(ref_clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmd_clear(cmd_clear),
        .conv_done(conv_done), .ch0_data(ch0_data), .integ_halt(integ_halt),
        .int_out(int_out), .int_oe_n(int_oe_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n)
    );

    ltsi_host_model host (
        .scl(scl), .host_pull(host_pull), .rival_pull(rival_pull), .sda(sda)
    );

    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_byte

    task automatic check_bit(input string what, input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
        end
    endtask : check_bit

    // one-cycle byte write on the internal register port
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk) #1;
        reg_wr_en = 1'b1;
        reg_addr = addr;
        reg_wdata = data;
        @(posedge ref_clk) #1;
        reg_wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge ref_clk) #1;
        reg_addr = addr;
        repeat (2) @(posedge ref_clk);
        #1 check_byte("reg_rdata", exp, reg_rdata);
    endtask : rd

    // conversion pulse, then one cycle for the interrupt flop to land
    task automatic conv(input logic [15:0] d);
        @(posedge ref_clk) #1;
        conv_done = 1'b1;
        ch0_data = d;
        @(posedge ref_clk) #1;
        conv_done = 1'b0;
        @(posedge ref_clk) #1;
    endtask : conv

    task automatic clear();
        @(posedge ref_clk) #1;
        cmd_clear = 1'b1;
        @(posedge ref_clk) #1;
        cmd_clear = 1'b0;
        @(posedge ref_clk) #1;
    endtask : clear

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence takes a few microseconds
    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end

    initial begin
        n_errors = 0;
        checks_done = 0;
        reset = 1'b1;
        reg_wr_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cmd_clear = 1'b0;
        conv_done = 1'b0;
        ch0_data = 16'h0000;
        repeat (2) @(posedge ref_clk);
        #1 reset = 1'b0;
        // reset values, unmapped address reads zero
        for (int a = 2; a <= 7; a++) begin
            rd(8'(a), 8'h00);
        end
        check_bit("int_pin", 1'b1, int_pin);
        // thresholds: low 0100, high 0200, low byte at lower address
        wr(8'h03, 8'h00);
        wr(8'h04, 8'h01);
        wr(8'h05, 8'h00);
        wr(8'h06, 8'h02);
        rd(8'h04, 8'h01);
        rd(8'h06, 8'h02);
        // mode off never drives the pin; reserved bit written as zero
        wr(8'h02, 8'h01);
        rd(8'h02, 8'h01);
        conv(16'h0050);
        check_bit("int_oe_n off", 1'b1, int_oe_n);
        // level mode, persistence one: result equal to low threshold
        wr(8'h02, 8'h11);
        conv(16'h0100);
        check_bit("int_oe_n low eq", 1'b0, int_oe_n);
        check_bit("int_pin", 1'b0, int_pin);
        repeat (4) @(posedge ref_clk);
        check_bit("int_oe_n held", 1'b0, int_oe_n);
        clear();
        check_bit("int_oe_n cleared", 1'b1, int_oe_n);
        conv(16'h0200);
        check_bit("int_oe_n high eq", 1'b1, int_oe_n);
        conv(16'h0201);
        check_bit("int_oe_n above", 1'b0, int_oe_n);
        clear();
        // persistence zero: in-range result still interrupts
        wr(8'h02, 8'h10);
        conv(16'h0150);
        check_bit("int_oe_n every", 1'b0, int_oe_n);
        clear();
        // persistence three: an in-range result restarts the count
        wr(8'h02, 8'h13);
        conv(16'h0050);
        conv(16'h0050);
        conv(16'h0150);
        conv(16'h0050);
        conv(16'h0050);
        check_bit("int_oe_n two outs", 1'b1, int_oe_n);
        conv(16'h0050);
        check_bit("int_oe_n three outs", 1'b0, int_oe_n);
        clear();
        // halt on interrupt, then resume by clearing
        wr(8'h02, 8'h51);
        conv(16'h0300);
        check_bit("integ_halt", 1'b1, integ_halt);
        clear();
        check_bit("integ_halt resumed", 1'b0, integ_halt);
        // alert mode: a lower-address rival wins, then a clean response
        wr(8'h02, 8'h21);
        conv(16'h0300);
        host.ara(1'b1, got, acked);
        check_byte("ara rival byte", {7'h10, 1'b0}, got);
        repeat (4) @(posedge ref_clk);
        check_bit("int_oe_n lost", 1'b0, int_oe_n);
        host.ara(1'b0, got, acked);
        check_bit("ara ack", 1'b1, acked);
        check_byte("ara byte", {DEV_ADDR, 1'b0}, got);
        repeat (4) @(posedge ref_clk);
        check_bit("int_oe_n won", 1'b1, int_oe_n);
        check_bit("sda released", 1'b1, sda_oe_n);
        // test mode sets at once and is cleared like alert mode
        wr(8'h02, 8'h30);
        check_bit("int_oe_n test", 1'b0, int_oe_n);
        host.ara(1'b0, got, acked);
        check_byte("ara test byte", {DEV_ADDR, 1'b0}, got);
        repeat (4) @(posedge ref_clk);
        check_bit("int_oe_n test clr", 1'b1, int_oe_n);
        wrap_up();
    end
endmodule : ltsi_core_bench
